// [logic/ubm_cfg.svh]
`ifndef UBM_CFG_SVH
`define UBM_CFG_SVH

// User-bit mode selector codes
`define UBM_MODE_ZERO   2'h0
`define UBM_MODE_BLOCK  2'h1
`define UBM_MODE_RSVD   2'h2
`define UBM_MODE_CONB   2'h3

// Information unit layout
`define UBM_UNIT_BITS   8
`define UBM_UNIT_LAST   3'h7
`define UBM_Q_POS       6
`define UBM_Q_BITS      96

// Message framing
`define UBM_MIN_UNITS   8'h03
`define UBM_MAX_UNITS   8'h81
`define UBM_MAX_FILL    4'h8
`define UBM_GAP_LAST    4'h8
`define UBM_SAT4        4'hf
`define UBM_SAT8        8'hff

// Buffer shape
`define UBM_FIFO_WIDTH  9
`define UBM_FIFO_DEPTH  256
`define UBM_CNT_W       9

`endif

// [logic/ubm_fifo.sv]
`timescale 1ns/1ps
`default_nettype none

module ubm_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 256
) (
    input  wire logic             clk,      // System clock
    input  wire logic             nrst,     // Async reset, active low
    input  wire logic             flush,    // Synchronous clear of pointers, count and head
    input  wire logic             inValid,  // Write request
    input  wire logic [WIDTH-1:0] inData,   // Write data
    output logic                  inReady,  // Room for one more word
    output logic                  outValid, // Head word available
    output logic      [WIDTH-1:0] outData,  // Head word, registered
    input  wire logic             outReady  // Head word taken
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    typedef struct packed {
        logic [AW-1:0]    wrPtr;
        logic [AW-1:0]    rdPtr;
        logic [CW-1:0]    count;
        logic             oValid;
        logic [WIDTH-1:0] oData;
    } ubm_fifo_state_type;

    ubm_fifo_state_type s_reg;
    ubm_fifo_state_type s_next;
    logic [WIDTH-1:0]   mem [DEPTH];
    logic               push;
    logic               load;

    assign inReady  = (s_reg.count != CW'(DEPTH));
    assign outValid = s_reg.oValid;
    assign outData  = s_reg.oData;

    always_comb begin
        s_next = s_reg;
        push   = inValid && inReady;
        // Prefetch keeps the head in a register so the reader never waits
        load   = (s_reg.count != '0) && (!s_reg.oValid || outReady);
        if (push) begin
            s_next.wrPtr = s_reg.wrPtr + AW'(1);
        end
        if (load) begin
            s_next.rdPtr  = s_reg.rdPtr + AW'(1);
            s_next.oValid = 1'b1;
            s_next.oData  = mem[s_reg.rdPtr];
        end else if (outReady) begin
            s_next.oValid = 1'b0;
        end
        s_next.count = s_reg.count + {{AW{1'b0}}, push}
                                   - {{AW{1'b0}}, load};
        if (flush) begin
            s_next = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (push && !flush) begin
            mem[s_reg.wrPtr] <= inData;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

endmodule // ubm_fifo

`default_nettype wire

// [logic/ubm_pkg.sv]
`include "ubm_cfg.svh"

package ubm_pkg;

    typedef enum logic [2:0] {
        RD_IDLE = 3'b001,
        RD_SEND = 3'b010,
        RD_FILL = 3'b100
    } ubm_rd_state_type;

    typedef struct packed {
        logic                        last;
        logic [`UBM_UNIT_BITS-1:0]   unit;
    } ubm_word_type;

    typedef struct packed {
        logic                        valid;
        ubm_word_type                data;
    } ubm_write_type;

    typedef struct packed {
        // Receive side
        logic                        inUnit;
        logic [2:0]                  bitCnt;
        logic [`UBM_UNIT_BITS-1:0]   shift;
        logic [3:0]                  zeroRun;
        logic                        msgOpen;
        logic [7:0]                  units;
        logic                        pendValid;
        logic [`UBM_UNIT_BITS-1:0]   pendUnit;
        logic [3:0]                  minFill;
        logic [`UBM_Q_BITS-1:0]      qShift;
        ubm_write_type               wr;
        logic [`UBM_CNT_W-1:0]       committed;
        logic                        flush;
        // Transmit side
        ubm_rd_state_type            rd;
        logic [`UBM_UNIT_BITS-1:0]   rdShift;
        logic                        rdLast;
        logic [3:0]                  bitLeft;
        logic [3:0]                  fillCnt;
        logic [3:0]                  gap;
        // Outputs
        logic                        outBit;
        logic                        irq;
        logic                        qValid;
        logic [`UBM_Q_BITS-1:0]      qSubcode;
    } ubm_state_type;

endpackage

// [logic/ubm_user_bit_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ubm_cfg.svh"

// Function
// [R1] A unit is eight bits: a leading 1 then seven payload bits.
// [R2] A message is recognised when it holds 3 to 129 units.
// [R3] Up to eight zeros between units keep them in one message.
// [R4] Nine or more zeros in a row end the message.
// [R5] Q bits of received units are gathered and presented as sub-code.
// [R6] Consumer mode B sends a message only after it is fully stored.
// [R7] Only units enter the FIFO; filler zeros are never written.
// [R8] Output filler between units equals the shortest input filler seen.
// [R9] An empty FIFO sends zeros until a whole message is stored.
// [R10] Faster output lengthens inter-message zeros, never splits messages.
// [R11] Every bit of every unit passes through; none dropped or repeated.
// [R12] An overwrite of unread data clears the whole FIFO synchronously.
// [R13] An overwrite raises an interrupt when enabled.
// [R14] Source pads each message with enough zeros to avoid overwrite.
// [R15] The reserved mode setting does nothing; it behaves as all zeros.
// [R16] Four mode settings: zeros, block, reserved, consumer mode B.
// [R17] All-zeros mode sends only zero user bits.
// [R18] The FIFO holds at least one 129-unit message.
// [R19] Message and pointer state pass safely from write to read side.
module ubm_user_bit_fifo (
    input  wire logic                   clk,          // 100 MHz clock
    input  wire logic                   nrst,         // Async reset, low
    input  wire logic [1:0]             mode,         // User-bit mode
    input  wire logic                   irqEn,        // Overwrite irq enable
    input  wire logic                   inBit,        // Received user bit
    input  wire logic                   inBitValid,   // Input frame strobe
    input  wire logic                   outBitReq,    // Output frame strobe
    output logic                        outBit,       // Transmit user bit
    output logic                        overwriteIrq, // Overwrite pulse
    output logic                        qValid,       // Sub-code update
    output logic [`UBM_Q_BITS-1:0]      qSubcode      // Collected Q bits
);

    ubm_pkg::ubm_state_type s_reg;
    ubm_pkg::ubm_state_type s_next;

    logic                        modeB;
    logic                        overflow;
    logic                        fifoInReady;
    logic                        fifoOutValid;
    ubm_pkg::ubm_word_type       fifoOutData;
    logic                        pop;
    logic                        incMsg;
    logic                        decMsg;
    logic [`UBM_UNIT_BITS-1:0]   unitDone;

    assign outBit       = s_reg.outBit;
    assign overwriteIrq = s_reg.irq;
    assign qValid       = s_reg.qValid;
    assign qSubcode     = s_reg.qSubcode;

    // Deep enough for one longest message plus the start of the next
    ubm_fifo #(
        .WIDTH (`UBM_FIFO_WIDTH),
        .DEPTH (`UBM_FIFO_DEPTH)
    ) u_fifo ( // R18
        .clk      (clk),
        .nrst     (nrst),
        .flush    (s_reg.flush),
        .inValid  (s_reg.wr.valid),
        .inData   (s_reg.wr.data),
        .inReady  (fifoInReady),
        .outValid (fifoOutValid),
        .outData  (fifoOutData),
        .outReady (pop)
    );

    always_comb begin
        s_next        = s_reg;
        s_next.wr     = '0;
        s_next.flush  = 1'b0;
        s_next.irq    = 1'b0;
        s_next.qValid = 1'b0;
        pop           = 1'b0;
        incMsg        = 1'b0;
        decMsg        = 1'b0;
        unitDone      = {s_reg.shift[`UBM_UNIT_BITS-2:0], inBit};
        modeB         = (mode == `UBM_MODE_CONB); // R16 R15
        // A write the FIFO could not take would overwrite unread data
        overflow      = s_reg.wr.valid && !fifoInReady;

        if (s_reg.wr.valid && s_reg.wr.data.last && fifoInReady) begin
            incMsg = 1'b1; // R19
        end

        // ---------------- Receive side ----------------
        if (!modeB || overflow) begin
            s_next.inUnit    = 1'b0;
            s_next.zeroRun   = `UBM_SAT4;
            s_next.msgOpen   = 1'b0;
            s_next.pendValid = 1'b0;
            s_next.units     = '0;
            s_next.committed = '0; // R12
            s_next.flush     = 1'b1; // R12
            s_next.irq       = overflow && irqEn; // R13
            s_next.rd        = ubm_pkg::RD_IDLE;
            s_next.gap       = `UBM_SAT4;
            incMsg           = 1'b0;
        end else if (inBitValid) begin
            if (s_reg.inUnit) begin
                s_next.shift  = unitDone;
                s_next.bitCnt = s_reg.bitCnt + 3'h1;
                if (s_reg.bitCnt == `UBM_UNIT_LAST) begin // R1
                    s_next.inUnit  = 1'b0;
                    s_next.zeroRun = '0;
                    s_next.qShift  = {s_reg.qShift[`UBM_Q_BITS-2:0],
                                      unitDone[`UBM_Q_POS]}; // R5
                    // Hold one unit back so the last one can be flagged
                    if (s_reg.pendValid) begin
                        s_next.wr.valid     = 1'b1; // R7 R11
                        s_next.wr.data.last = 1'b0;
                        s_next.wr.data.unit = s_reg.pendUnit;
                    end
                    s_next.pendValid = 1'b1;
                    s_next.pendUnit  = unitDone;
                    if (s_reg.units != `UBM_SAT8) begin
                        s_next.units = s_reg.units + 8'h01;
                    end
                end
            end else if (inBit) begin
                s_next.inUnit = 1'b1; // R1
                s_next.shift  = 8'h01;
                s_next.bitCnt = 3'h1;
                if (s_reg.msgOpen && s_reg.zeroRun < s_reg.minFill) begin
                    s_next.minFill = s_reg.zeroRun; // R3 R8
                end
                if (!s_reg.msgOpen) begin
                    s_next.msgOpen = 1'b1;
                    s_next.units   = '0;
                    s_next.qShift  = '0;
                end
            end else begin
                if (s_reg.zeroRun != `UBM_SAT4) begin
                    s_next.zeroRun = s_reg.zeroRun + 4'h1; // R7
                end
                if (s_reg.zeroRun == `UBM_GAP_LAST && s_reg.msgOpen) begin
                    s_next.msgOpen   = 1'b0; // R4
                    s_next.pendValid = 1'b0;
                    if (s_reg.pendValid) begin
                        s_next.wr.valid     = 1'b1; // R4
                        s_next.wr.data.last = 1'b1;
                        s_next.wr.data.unit = s_reg.pendUnit;
                    end
                    if (s_reg.units >= `UBM_MIN_UNITS &&
                        s_reg.units <= `UBM_MAX_UNITS) begin
                        s_next.qSubcode = s_reg.qShift; // R2 R5
                        s_next.qValid   = 1'b1;
                    end
                end
            end
        end

        // ---------------- Transmit side ----------------
        if (outBitReq) begin
            s_next.outBit = 1'b0; // R17 R9
        end
        if (outBitReq && modeB && !overflow) begin
            case (s_reg.rd)
                ubm_pkg::RD_IDLE: begin
                    if (s_reg.gap != `UBM_SAT4) begin
                        s_next.gap = s_reg.gap + 4'h1;
                    end
                    // Gap of nine zeros is kept before the next message
                    if (s_reg.committed != '0 && fifoOutValid &&
                        s_reg.gap >= `UBM_GAP_LAST) begin // R6 R9 R10
                        pop            = 1'b1;
                        s_next.rdShift = fifoOutData.unit;
                        s_next.rdLast  = fifoOutData.last;
                        s_next.bitLeft = 4'h8;
                        s_next.rd      = ubm_pkg::RD_SEND;
                    end
                end
                ubm_pkg::RD_SEND: begin
                    s_next.outBit  = s_reg.rdShift[`UBM_UNIT_BITS-1]; // R11
                    s_next.rdShift = {s_reg.rdShift[`UBM_UNIT_BITS-2:0],
                                      1'b0};
                    s_next.bitLeft = s_reg.bitLeft - 4'h1;
                    if (s_reg.bitLeft == 4'h1) begin
                        if (s_reg.rdLast) begin
                            decMsg     = 1'b1;
                            s_next.rd  = ubm_pkg::RD_IDLE;
                            s_next.gap = '0;
                        end else if (s_reg.minFill != '0) begin
                            s_next.rd      = ubm_pkg::RD_FILL; // R8
                            s_next.fillCnt = s_reg.minFill;
                        end else if (fifoOutValid) begin
                            pop            = 1'b1; // R10
                            s_next.rdShift = fifoOutData.unit;
                            s_next.rdLast  = fifoOutData.last;
                            s_next.bitLeft = 4'h8;
                        end else begin
                            s_next.rd  = ubm_pkg::RD_IDLE;
                            s_next.gap = '0;
                        end
                    end
                end
                ubm_pkg::RD_FILL: begin
                    s_next.fillCnt = s_reg.fillCnt - 4'h1; // R8
                    if (s_reg.fillCnt == 4'h1) begin
                        if (fifoOutValid) begin
                            pop            = 1'b1; // R10
                            s_next.rdShift = fifoOutData.unit;
                            s_next.rdLast  = fifoOutData.last;
                            s_next.bitLeft = 4'h8;
                            s_next.rd      = ubm_pkg::RD_SEND;
                        end else begin
                            s_next.rd  = ubm_pkg::RD_IDLE;
                            s_next.gap = '0;
                        end
                    end
                end
                default: begin
                    s_next.rd = ubm_pkg::RD_IDLE;
                end
            endcase
        end

        // Both sides may move the count in one cycle
        if (!overflow && modeB) begin
            s_next.committed = s_reg.committed
                             + {{(`UBM_CNT_W-1){1'b0}}, incMsg}
                             - {{(`UBM_CNT_W-1){1'b0}}, decMsg}; // R19
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_reg         <= '0;
            s_reg.zeroRun <= `UBM_SAT4;
            s_reg.minFill <= `UBM_MAX_FILL;
            s_reg.gap     <= `UBM_SAT4;
            s_reg.rd      <= ubm_pkg::RD_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // ---------------- Checks ----------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    property p_zero_mode;
        outBitReq && mode != `UBM_MODE_CONB |=> !outBit;
    endproperty
    a_zero_mode: assert property (p_zero_mode) // R17
        else $error("user bit not zero outside consumer mode");

    property p_idle_zero;
        outBitReq && s_reg.rd == ubm_pkg::RD_IDLE |=> !outBit;
    endproperty
    a_idle_zero: assert property (p_idle_zero) // R9
        else $error("user bit sent while no message ready");

    property p_flush;
        s_reg.wr.valid && !fifoInReady
            |=> s_reg.flush && s_reg.committed == '0 ##1 !fifoOutValid;
    endproperty
    a_flush: assert property (p_flush) // R12
        else $error("overwrite did not clear the buffer");

    property p_irq;
        s_reg.wr.valid && !fifoInReady |=> overwriteIrq == $past(irqEn);
    endproperty
    a_irq: assert property (p_irq) // R13
        else $error("overwrite interrupt wrong");

    property p_whole_msg;
        s_reg.rd == ubm_pkg::RD_IDLE ##1 s_reg.rd == ubm_pkg::RD_SEND
            |-> $past(s_reg.committed) != '0;
    endproperty
    a_whole_msg: assert property (p_whole_msg) // R6
        else $error("message started before fully stored");

    property p_gap_end;
        inBitValid && !inBit && !s_reg.inUnit && modeB && !overflow &&
        s_reg.zeroRun == `UBM_GAP_LAST && s_reg.pendValid
            |=> s_reg.wr.valid && s_reg.wr.data.last ##1 !s_reg.wr.valid;
    endproperty
    a_gap_end: assert property (p_gap_end) // R4
        else $error("ninth zero did not close the message");

    property p_no_filler;
        inBitValid && !inBit && !s_reg.inUnit &&
        s_reg.zeroRun != `UBM_GAP_LAST |=> !s_reg.wr.valid;
    endproperty
    a_no_filler: assert property (p_no_filler) // R7
        else $error("filler zero written to buffer");

    property p_start_bit;
        s_reg.wr.valid |-> s_reg.wr.data.unit[`UBM_UNIT_BITS-1];
    endproperty
    a_start_bit: assert property (p_start_bit) // R1
        else $error("stored unit lacks its start bit");

    property p_fill_len;
        $rose(s_reg.rd == ubm_pkg::RD_FILL)
            |-> s_reg.fillCnt == $past(s_reg.minFill);
    endproperty
    a_fill_len: assert property (p_fill_len) // R8
        else $error("output filler length wrong");

    property p_min_fill;
        inBitValid && inBit && !s_reg.inUnit && s_reg.msgOpen &&
        modeB && !overflow && s_reg.zeroRun < s_reg.minFill
            |=> s_reg.minFill == $past(s_reg.zeroRun);
    endproperty
    a_min_fill: assert property (p_min_fill) // R3
        else $error("shortest filler not tracked");

    property p_qvalid;
        qValid |-> $past(s_reg.units) >= `UBM_MIN_UNITS &&
                   $past(s_reg.units) <= `UBM_MAX_UNITS;
    endproperty
    a_qvalid: assert property (p_qvalid) // R2
        else $error("sub-code presented for invalid message");

    // A stored message must never run dry between two of its units
    property p_no_split;
        outBitReq && modeB && !overflow && s_reg.rd == ubm_pkg::RD_FILL &&
        s_reg.fillCnt == 4'h1 |-> fifoOutValid;
    endproperty
    a_no_split: assert property (p_no_split) // R10
        else $error("message split by an empty buffer");

    property p_send_bit;
        outBitReq && modeB && !overflow && s_reg.rd == ubm_pkg::RD_SEND
            |=> outBit == $past(s_reg.rdShift[`UBM_UNIT_BITS-1]);
    endproperty
    a_send_bit: assert property (p_send_bit) // R11
        else $error("sent bit differs from stored unit");

    property p_commit_count;
        decMsg |-> s_reg.committed != '0;
    endproperty
    a_commit_count: assert property (p_commit_count) // R19
        else $error("message count would underflow");

endmodule // ubm_user_bit_fifo

`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ubm_cfg.svh"

module testbench;
    logic                   clk;
    logic                   nrst;
    logic [1:0]             mode;
    logic                   irqEn;
    logic                   inBit;
    logic                   inBitValid;
    logic                   outBitReq;
    logic                   outBit;
    logic                   overwriteIrq;
    logic                   qValid;
    logic [`UBM_Q_BITS-1:0] qSubcode;
    logic [`UBM_Q_BITS-1:0] gotQ;
    logic [`UBM_Q_BITS-1:0] expQ;
    logic [7:0]             expUnits[$];
    logic [7:0]             cur;
    logic                   reqD1;
    logic                   reqD2;
    logic                   reqOn;
    logic                   allowOut;
    logic                   ignore;
    logic                   inU;
    logic                   haveUnit;
    int                     n_mismatch;
    int                     checks_done;
    int                     qSeen;
    int                     irqSeen;
    int                     minFillExp;
    int                     zeroRun;
    int                     bitCnt;
    int                     m;
    int                     e;
    int                     k;

    ubm_user_bit_fifo ubm_user_bit_fifo_inst (
        .clk          (clk),
        .nrst         (nrst),
        .mode         (mode),
        .irqEn        (irqEn),
        .inBit        (inBit),
        .inBitValid   (inBitValid),
        .outBitReq    (outBitReq),
        .outBit       (outBit),
        .overwriteIrq (overwriteIrq),
        .qValid       (qValid),
        .qSubcode     (qSubcode)
    );

    ubm_source_model ubm_source_model_inst (
        .clk        (clk),
        .inBit      (inBit),
        .inBitValid (inBitValid)
    );

    always #5 clk = ~clk;

    // Irregular output frame rate, never closer than two cycles
    always begin
        @(posedge clk);
        #1;
        if (reqOn) begin
            outBitReq = 1'b1;
            @(posedge clk);
            #1;
            outBitReq = 1'b0;
            repeat ($urandom_range(1, 4)) @(posedge clk);
        end
    end

    always @(posedge clk) begin
        reqD1 <= outBitReq;
        reqD2 <= reqD1;
    end

    // Outputs are read at the falling edge, clear of the update edge
    always @(negedge clk) begin
        if (qValid === 1'b1) begin
            qSeen++;
            gotQ = qSubcode;
        end
        if (overwriteIrq === 1'b1) irqSeen++;
        if (reqD2 === 1'b1) decode(outBit);
    end

    task automatic check_unit(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected unit at %0t: %h vs %h", $time, got, exp);
        end
    endtask

    task automatic check_val(input logic [95:0] got, input logic [95:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected value at %0t: %h vs %h", $time, got, exp);
        end
    endtask

    task automatic decode(input logic b);
        if (inU) begin
            cur = {cur[6:0], b};
            bitCnt++;
            if (bitCnt == 8) begin
                inU      = 1'b0;
                haveUnit = 1'b1;
                if (!ignore)
                    check_unit(cur, expUnits.size() > 0 ?
                        expUnits.pop_front() : 8'h00);
            end
        end else if (b === 1'b1) begin
            if (!ignore && (expUnits.size() == 0 || !allowOut))
                check_val(96'h1, 96'h0);
            if (!ignore && haveUnit && zeroRun < 9)
                check_val(96'(zeroRun), 96'(minFillExp));
            inU     = 1'b1;
            cur     = 8'h01;
            bitCnt  = 1;
            zeroRun = 0;
        end else begin
            zeroRun++;
        end
    endtask

    task automatic play(input int n, input int fill, input int gap,
                        input bit keep);
        logic [7:0] u;
        int         q0;
        int         i;
        expQ = '0;
        q0   = qSeen;
        for (i = 0; i < n; i++) begin
            u = {1'b1, 7'($urandom)};
            ubm_source_model_inst.txq.push_back(u);
            if (keep) expUnits.push_back(u);
            expQ = {expQ[94:0], u[6]};
        end
        if (mode == `UBM_MODE_CONB && n > 1 && fill < minFillExp)
            minFillExp = fill;
        ubm_source_model_inst.send_msg(fill, gap);
        @(posedge clk);
        #1;
        if (mode != `UBM_MODE_CONB || n < 3 || n > 129) begin
            check_val(96'(qSeen - q0), 96'h0);
        end else begin
            check_val(96'(qSeen - q0), 96'h1);
            check_val(gotQ, expQ);
        end
    endtask

    task automatic drain();
        int t;
        for (t = 0; t < 20000 && expUnits.size() > 0; t++) @(posedge clk);
        check_val(96'(expUnits.size()), 96'h0);
        repeat (100) @(posedge clk);
        #1;
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #(100000 * 10);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        {clk, nrst, mode, irqEn, outBitReq, reqOn, ignore} = '0;
        {inU, haveUnit, reqD1, reqD2, cur, gotQ, expQ} = '0;
        {zeroRun, bitCnt, n_mismatch, checks_done, qSeen, irqSeen} = '0;
        allowOut   = 1'b1;
        minFillExp = 8;
        void'($urandom(32'hef149d50));
        repeat (20) @(posedge clk);
        #1;
        nrst  = 1'b1;
        reqOn = 1'b1;
        for (m = 0; m < 3; m++) begin
            mode = 2'(m);
            play(4, 2, 12, 1'b0);
            drain();
        end
        mode     = `UBM_MODE_CONB;
        allowOut = 1'b0;
        play(4, 3, 9, 1'b1);
        allowOut = 1'b1;
        drain();
        play(2, 1, 9, 1'b1);
        drain();
        play(3, 8, 9, 1'b1);
        play(3, 5, 9, 1'b1);
        drain();
        for (m = 0; m < 6; m++)
            // Padding covers ten units of eight-zero filler at 3:2 rates
            play(3 + $urandom_range(0, 7), $urandom_range(1, 8),
                 90 + $urandom_range(0, 30), 1'b1);
        drain();
        // Output stalled: 256 stored plus the prefetched head, so the
        // 258th unit finds the buffer full
        for (e = 1; e >= 0; e--) begin
            irqEn = e[0];
            reqOn = 1'b0;
            k     = irqSeen;
            play(258, 1, 12, 1'b0);
            check_val(96'(irqSeen - k), 96'(e));
            ignore = 1'b1;
            reqOn  = 1'b1;
            repeat (800) @(posedge clk);
            #1;
            {inU, haveUnit, ignore} = '0;
            zeroRun = 0;
            play(3, 1, 9, 1'b1);
            drain();
        end
        print_verdict();
    end
endmodule // testbench

`default_nettype wire

// [test/ubm_source_model.sv]
`timescale 1ns/1ps
`default_nettype none

module ubm_source_model (
    input  wire logic clk,        // System clock
    output logic      inBit,      // Received user bit
    output logic      inBitValid  // One strobe per input frame
);
    logic [7:0] txq[$];

    initial begin
        inBit      = 1'b0;
        inBitValid = 1'b0;
    end

    // Strobes four cycles apart; the line shows junk between strobes
    // so a design that samples off the strobe cannot pass by luck
    task automatic send_bit(input logic b);
        inBit      = b;
        inBitValid = 1'b1;
        @(posedge clk);
        #1;
        inBit      = ~b;
        inBitValid = 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic send_msg(input int fill, input int gap);
        logic [7:0] u;
        int         k;
        int         i;
        k = 0;
        while (txq.size() > 0) begin
            u = txq.pop_front();
            if (k > 0)
                for (i = 0; i < fill; i++) send_bit(1'b0);
            for (i = 7; i >= 0; i--) send_bit(u[i]);
            k++;
        end
        for (i = 0; i < gap; i++) send_bit(1'b0);
    endtask
endmodule // ubm_source_model

`default_nettype wire
